//--- logic/stme_pkg.sv
// Package: constants and types for the standard timer mode engine
package stme_pkg;

    // ------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam logic [2:0] STME_ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] STME_ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] STME_ADDR_CMPA = 3'h2;
    localparam logic [2:0] STME_ADDR_PERIOD = 3'h3;
    localparam logic [2:0] STME_ADDR_COUNT = 3'h4;
    localparam logic [2:0] STME_ADDR_FLAGS = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STME_CTRL0_ENABLE_BIT = 0;
    localparam int STME_FLAG_A_BIT = 0;
    localparam int STME_FLAG_P_BIT = 1;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int STME_CNT_W = 10;
    localparam logic [9:0] STME_CNT_MAX = 10'h3FF;
    localparam logic [9:0] STME_CNT_ZERO = 10'h000;
    localparam logic [7:0] STME_CTRL1_RST = 8'h00;
    localparam logic [2:0] STME_PERIOD_ZERO = 3'h0;
    localparam int STME_PERIOD_LSB = 7;

    // Operating modes held in the two-bit mode field
    typedef enum logic [1:0] {
        STME_MODE_CMP = 2'b00,
        STME_MODE_CAP = 2'b01,
        STME_MODE_PWM = 2'b10,
        STME_MODE_TMR = 2'b11
    } stme_mode_t;

    // Pin-function codes
    localparam logic [1:0] STME_PF_00 = 2'b00;
    localparam logic [1:0] STME_PF_01 = 2'b01;
    localparam logic [1:0] STME_PF_10 = 2'b10;
    localparam logic [1:0] STME_PF_11 = 2'b11;

    // Control byte one, packed in field order, msb first
    typedef struct packed {
        stme_mode_t mode;
        logic [1:0] pin_function;
        logic output_initial_level;
        logic output_invert;
        logic duty_period_swap;
        logic clear_source_select;
    } stme_ctrl1_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [9:0] wdata;
    } stme_req_t;

endpackage : stme_pkg

//--- logic/stme_top.sv
// Module: standard timer mode engine with register port and output pin
//
// Operation
// - Mode field 00 selects compare match output mode.
// - Clear-source low: clear on P match or overflow; set both flags.
// - Clear-source high: clear on A match; only A flag, never P.
// - Compare A zero: count wraps at 3FF, no A flag.
// - Output pin changes only on A match; P match leaves it.
// - Pin-function picks high, low, toggle or no change on A match.
// - Rising counter-enable loads output with initial level bit.
// - Mode 11 counts like compare mode but does not drive pin.
// - PWM active with mode 10 and pin-function 10.
// - PWM swap bit picks period and duty; clear-source ignored.
// - PWM level from initial bit, inverted by invert; 00/01 force.
// - Swap clear: period is coarse value times 128, or 1024; duty A.
// - Duty at or above period holds active level whole period.
// - Swap set: period from A; duty coarse times 128 or 1024.
// - Single pulse with mode 10, pin-function 11, held fixed.
// - External pin edge sets enable; rising enable starts pulse.
// - A match clears enable, ends pulse, raises flag; sw clear too.
// - Single pulse count resets only on rising enable; P unused.
// - Mode 01 is capture; pin-function selects edges or disables.
// - Capture edge copies count into compare A and raises flag.
// - Capture P match clears count, raises flag; zero lets it wrap.
// - Capture edge code: 00 rise, 01 fall, 10 both, 11 off.
// - Coarse period compares counter bits 9 to 7 only; in PWM the full count is compared with p_len.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module stme_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [2:0] reg_addr,
    input wire logic [9:0] reg_wdata,
    output logic [9:0] reg_rdata,
    // Pins
    input wire logic ext_clock_pin,
    input wire logic capture_input_pin,
    output logic timer_out,
    output logic timer_out_en,
    // Flags
    output logic compare_a_flag,
    output logic compare_p_flag
);
    import stme_pkg::*;

    stme_req_t req;
    stme_ctrl1_t ctrl_q;
    logic counter_enable_q, en_prev_q;
    logic [9:0] count_q, count_d;
    logic [9:0] cmpa_q;
    logic [2:0] period_q;
    logic flag_a_q, flag_p_q;
    logic out_q;
    logic ext_prev_q, cap_prev_q;
    logic [9:0] rdata_q;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire is_cmp = ctrl_q.mode == STME_MODE_CMP;
    wire is_tmr = ctrl_q.mode == STME_MODE_TMR;
    wire is_cap = ctrl_q.mode == STME_MODE_CAP;
    wire is_pwmgrp = ctrl_q.mode == STME_MODE_PWM;
    wire is_single = is_pwmgrp && ctrl_q.pin_function == STME_PF_11;
    wire is_pwm = is_pwmgrp && !is_single;
    wire cmp_like = is_cmp || is_tmr;

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    // Coarse value only looks at the top three count bits
    wire p_hit = period_q != STME_PERIOD_ZERO &&
        count_q[STME_CNT_W-1:STME_PERIOD_LSB] == period_q;
    wire at_max = count_q == STME_CNT_MAX;
    wire a_hit = cmpa_q != STME_CNT_ZERO && count_q == cmpa_q;
    // Zero coarse value means the period runs to overflow (1024)
    wire p_wrap = p_hit || (period_q == STME_PERIOD_ZERO && at_max);
    // Period length in clocks, used by PWM duty test
    wire [10:0] p_len = (period_q == STME_PERIOD_ZERO) ? 11'h400 :
        {period_q, 7'h00, 1'b0} >> 1;
    wire swap = ctrl_q.duty_period_swap;
    // Last count of a coarse PWM period, so the period is exactly p_len
    wire p_last = ({1'b0, count_q} + 11'h001) == p_len;
    wire pwm_p_ev = swap ? p_hit : p_last;

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    wire wr_ctrl0 = req.wr && req.addr == STME_ADDR_CTRL0;
    wire wr_ctrl1 = req.wr && req.addr == STME_ADDR_CTRL1;
    wire wr_cmpa = req.wr && req.addr == STME_ADDR_CMPA;
    wire wr_period = req.wr && req.addr == STME_ADDR_PERIOD;
    wire wr_flags = req.wr && req.addr == STME_ADDR_FLAGS;
    wire en_rise = counter_enable_q && !en_prev_q;
    wire running = counter_enable_q && !en_rise;

    wire ext_edge = ext_clock_pin && !ext_prev_q;
    wire cap_rise = capture_input_pin && !cap_prev_q;
    wire cap_fall = !capture_input_pin && cap_prev_q;
    // Edge select for capture
    wire cap_edge = is_cap && running && (
        (ctrl_q.pin_function == STME_PF_00 && cap_rise) ||
        (ctrl_q.pin_function == STME_PF_01 && cap_fall) ||
        (ctrl_q.pin_function == STME_PF_10 && (cap_rise || cap_fall)));

    // Match events per mode, qualified by the counter running
    wire ev_a = running && a_hit && !is_cap;
    wire ev_p = running && !is_single && (is_pwm ? pwm_p_ev : p_hit);
    // Which compare clears the count
    wire clr_cmp = ctrl_q.clear_source_select ? a_hit : p_wrap;
    wire clr_pwm = swap ? (count_q == cmpa_q) : p_last;
    wire clr_cap = p_wrap;
    wire clr_now = running && ((cmp_like && clr_cmp) ||
        (is_pwm && clr_pwm) || (is_cap && clr_cap));

    // Flag raising
    wire set_a = ev_a || cap_edge;
    wire set_p = ev_p && !(cmp_like && ctrl_q.clear_source_select) ||
        (is_cap && running && p_hit);
    wire single_end = is_single && running && a_hit;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Enable: pin edge sets it in single pulse, A match clears it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= stme_ctrl1_t'(STME_CTRL1_RST);
            counter_enable_q <= 1'b0;
            en_prev_q <= 1'b0;
            cmpa_q <= STME_CNT_ZERO;
            period_q <= STME_PERIOD_ZERO;
        end else begin
            en_prev_q <= counter_enable_q;
            if (single_end) begin
                counter_enable_q <= 1'b0;
            end else if (is_single && ext_edge) begin
                counter_enable_q <= 1'b1;
            end else if (wr_ctrl0) begin
                counter_enable_q <= req.wdata[STME_CTRL0_ENABLE_BIT];
            end
            if (wr_ctrl1) begin
                ctrl_q <= stme_ctrl1_t'(req.wdata[7:0]);
            end
            // Capture load wins over a software write the same cycle
            if (cap_edge) begin
                cmpa_q <= count_q;
            end else if (wr_cmpa) begin
                cmpa_q <= req.wdata;
            end
            if (wr_period) begin
                period_q <= req.wdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Single pulse only resets on a rising enable
    always_comb begin
        count_d = count_q;
        if (en_rise) begin
            count_d = STME_CNT_ZERO;
        end else if (running) begin
            if (clr_now && !is_single) begin
                count_d = STME_CNT_ZERO;
            end else begin
                count_d = count_q + 10'h001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= STME_CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------
    // Flags: hardware set wins over a software clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
        end else begin
            flag_a_q <= set_a || (flag_a_q &&
                !(wr_flags && req.wdata[STME_FLAG_A_BIT]));
            flag_p_q <= set_p || (flag_p_q &&
                !(wr_flags && req.wdata[STME_FLAG_P_BIT]));
        end
    end

    // ------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------
    // PWM duty compare; duty at or above period stays active
    wire [10:0] duty_len = swap ? p_len : {1'b0, cmpa_q};
    wire [10:0] per_len = swap ? {1'b0, cmpa_q} : p_len;
    wire pwm_act = ({1'b0, count_q} < duty_len) ||
        (duty_len >= per_len);
    logic pwm_lvl;
    always_comb begin
        case (ctrl_q.pin_function)
            STME_PF_00: pwm_lvl = 1'b0;
            STME_PF_01: pwm_lvl = 1'b1;
            default: pwm_lvl = pwm_act;
        endcase
    end
    // Active level set by initial bit, then optional inversion
    wire pwm_pin = (pwm_lvl ? ctrl_q.output_initial_level :
        !ctrl_q.output_initial_level) ^ ctrl_q.output_invert;
    wire single_pin = (counter_enable_q ? ctrl_q.output_initial_level :
        !ctrl_q.output_initial_level) ^ ctrl_q.output_invert;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'b0;
            timer_out_en <= 1'b0;
        end else begin
            timer_out_en <= is_cmp || is_pwmgrp;
            if (is_cmp && en_rise) begin
                out_q <= ctrl_q.output_initial_level;
            end else if (is_cmp && ev_a) begin
                case (ctrl_q.pin_function)
                    STME_PF_01: out_q <= 1'b0;
                    STME_PF_10: out_q <= 1'b1;
                    STME_PF_11: out_q <= !out_q;
                    default: out_q <= out_q;
                endcase
            end else if (is_pwm) begin
                out_q <= counter_enable_q ? pwm_pin :
                    !ctrl_q.output_initial_level ^ ctrl_q.output_invert;
            end else if (is_single) begin
                out_q <= single_pin;
            end
        end
    end

    // ------------------------------------------------------------
    // Read port and sampled pins
    // ------------------------------------------------------------
    logic [9:0] rmux;
    always_comb begin
        case (req.addr)
            STME_ADDR_CTRL0: rmux = {9'h000, counter_enable_q};
            STME_ADDR_CTRL1: rmux = {2'h0, ctrl_q};
            STME_ADDR_CMPA: rmux = cmpa_q;
            STME_ADDR_PERIOD: rmux = {7'h00, period_q};
            STME_ADDR_COUNT: rmux = count_q;
            STME_ADDR_FLAGS: rmux = {8'h00, flag_p_q, flag_a_q};
            default: rmux = 10'h000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 10'h000;
            ext_prev_q <= 1'b0;
            cap_prev_q <= 1'b0;
        end else begin
            rdata_q <= req.rd ? rmux : 10'h000;
            ext_prev_q <= ext_clock_pin;
            cap_prev_q <= capture_input_pin;
        end
    end

    assign reg_rdata = rdata_q;
    assign timer_out = out_q;
    assign compare_a_flag = flag_a_q;
    assign compare_p_flag = flag_p_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cmp_clear_p: assert property (@(posedge core_clk) disable iff (!rst_n)
        running && cmp_like && !ctrl_q.clear_source_select && p_hit
        |=> count_q == STME_CNT_ZERO)
        else $error("count not cleared on P match");
    a_no_p_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        cmp_like && ctrl_q.clear_source_select && !flag_p_q
        && !is_cap |=> !flag_p_q)
        else $error("P flag raised with A clear");
    a_zero_a_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        running && cmp_like && cmpa_q == STME_CNT_ZERO && at_max
        |=> count_q == STME_CNT_ZERO)
        else $error("no wrap at max");
    a_init_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_cmp && en_rise |=> timer_out == $past(ctrl_q.output_initial_level))
        else $error("initial level not loaded");
    a_toggle_out: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_cmp && ev_a && ctrl_q.pin_function == STME_PF_11 && !en_rise
        |=> timer_out != $past(timer_out))
        else $error("toggle missing");
    a_single_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        single_end |=> !counter_enable_q ##0 compare_a_flag)
        else $error("single pulse not ended");
    a_cap_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_edge |=> cmpa_q == $past(count_q) && compare_a_flag)
        else $error("capture not loaded");
    a_flag_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        compare_a_flag && !wr_flags |=> compare_a_flag)
        else $error("flag dropped without clear");
    c_cmp_match: cover property (@(posedge core_clk) is_cmp && ev_a);
    c_pwm_wrap: cover property (@(posedge core_clk) is_pwm && clr_now);
    c_single: cover property (@(posedge core_clk) single_end);
    c_capture: cover property (@(posedge core_clk) cap_edge);

endmodule : stme_top

//--- test/stme_tb.sv
// Self-checking testbench for the standard timer mode engine
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        checks_done++; \
        if ((got) !== (ex)) begin \
            fail_count++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb;
    import stme_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd;
    logic [2:0] reg_addr;
    logic [9:0] reg_wdata, reg_rdata, a, d, e;
    logic ext_clock_pin, capture_input_pin, timer_out, timer_out_en;
    logic compare_a_flag, compare_p_flag, lv, cap;
    int fail_count, checks_done, cycles, n;
    integer seed;

    stme_top DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .ext_clock_pin(ext_clock_pin),
        .capture_input_pin(capture_input_pin), .timer_out(timer_out),
        .timer_out_en(timer_out_en), .compare_a_flag(compare_a_flag),
        .compare_p_flag(compare_p_flag));

    // 20 MHz core clock
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end

    // ----------------------------------------------------------------
    // Bus tasks and helpers
    // ----------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc

    // One-cycle write; a gap cycle keeps each strobe edge distinct
    task automatic wr(input logic [2:0] ad, input logic [9:0] dt);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : wr

    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [2:0] ad, output logic [9:0] dt);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 dt = reg_rdata;
    endtask : rd

    function automatic logic [9:0] mk(input logic [1:0] m, pf,
        input logic ini, inv, sw, cs);
        return {2'h0, m, pf, ini, inv, sw, cs};
    endfunction : mk

    // Pin level after a compare A match for each pin-function code
    function automatic logic cmp_out(input logic [1:0] pf, input logic ini);
        case (pf)
            2'h0: return ini;
            2'h1: return 1'h0;
            2'h2: return 1'h1;
            default: return ~ini;
        endcase
    endfunction : cmp_out

    // Timer is stopped before any mode change, flags cleared too
    task automatic cfg(input logic [9:0] c1, ca, input logic [2:0] p);
        wr(STME_ADDR_CTRL0, 10'h000);
        wr(STME_ADDR_CTRL1, c1);
        wr(STME_ADDR_CMPA, ca);
        wr(STME_ADDR_PERIOD, {7'h00, p});
        wr(STME_ADDR_FLAGS, 10'h003);
        wr(STME_ADDR_CTRL0, 10'h001);
    endtask : cfg

    // Count cycles that the pin spends at a given level
    task automatic meas(input logic l, input int k, output int c);
        c = 0;
        repeat (k) begin
            @(posedge core_clk);
            #1 if (timer_out === l) c++;
        end
    endtask : meas

    task automatic print_verdict;
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 60000) begin
            fail_count++;
            print_verdict;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h303c3846;
        {reg_wr, reg_rd, ext_clock_pin, capture_input_pin} = 4'h0;
        reg_addr = 3'h0;
        reg_wdata = 10'h000;
        rst_n = 1'h0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        // Reset values, field widths, unmapped index
        rd(STME_ADDR_CTRL1, d); `CHK("ctrl1", STME_CTRL1_RST, d)
        rd(STME_ADDR_FLAGS, d); `CHK("flags", 10'h000, d)
        wr(STME_ADDR_PERIOD, 10'h3FF);
        rd(STME_ADDR_PERIOD, d); `CHK("period", 10'h007, d)
        wr(3'h7, 10'h3FF);
        rd(3'h7, d); `CHK("unmapped", 10'h000, d)
        // Compare mode, clear on A, period below A, every pin code
        for (int p = 0; p < 4; p++) begin
            a = 10'(130 + $unsigned($random(seed)) % 200);
            lv = 1'($random(seed));
            cfg(mk(STME_MODE_CMP, p[1:0], lv, 1'h0, 1'h0, 1'h1), a, 3'h1);
            cyc(3);
            #1 `CHK("init", lv, timer_out)
            `CHK("out_en", 1'h1, timer_out_en)
            cyc(int'(a) + 10);
            #1 `CHK("flag_a", 1'h1, compare_a_flag)
            `CHK("no_flag_p", 1'h0, compare_p_flag)
            `CHK("cmp_out", cmp_out(p[1:0], lv), timer_out)
            rd(STME_ADDR_COUNT, d); `CHK("cnt_lo", 1'h1, d < 10'd30)
        end
        // Clear on P at 128, P match must leave the pin alone
        cfg(mk(STME_MODE_CMP, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0), 10'h005, 3'h1);
        cyc(300);
        #1 `CHK("both_a", 1'h1, compare_a_flag)
        `CHK("both_p", 1'h1, compare_p_flag)
        `CHK("p_keeps", 1'h1, timer_out)
        rd(STME_ADDR_COUNT, d); `CHK("cnt_p", 1'h1, d < 10'd128)
        wr(STME_ADDR_CTRL0, 10'h000);
        cyc(5);
        wr(STME_ADDR_FLAGS, 10'h001);
        rd(STME_ADDR_FLAGS, d); `CHK("w1c", 10'h002, d)
        // Timer mode, compare A zero: full wrap, no flags, pin undriven
        cfg(mk(STME_MODE_TMR, 2'h0, 1'h1, 1'h0, 1'h0, 1'h1), 10'h000, 3'h0);
        cyc(600);
        rd(STME_ADDR_COUNT, d); `CHK("wrap", 1'h1, d > 10'd512)
        cyc(600);
        #1 `CHK("no_a", 1'h0, compare_a_flag)
        `CHK("tmr_p", 1'h0, compare_p_flag)
        `CHK("tmr_en", 1'h0, timer_out_en)
        // PWM: random duty, inversion, forced codes, full duty, swap
        for (int k = 0; k < 6; k++) begin
            a = 10'(10 + $unsigned($random(seed)) % 110);
            lv = (k == 1) ? 1'h0 : 1'h1;
            e = 10'(2 * a);
            if (k == 2) e = 10'd0;
            if (k == 3 || k == 4 || k == 5) e = 10'd256;
            if (k == 4) a = 10'd200;
            if (k == 5) a = 10'd100;
            cfg(mk(STME_MODE_PWM, (k == 2) ? 2'h0 : (k == 3) ? 2'h1 : 2'h2,
                lv, k == 1, k == 5, 1'h1), a, 3'h1);
            cyc(300);
            meas(1'h1, 256, n);
            `CHK("pwm_duty", e, 10'(n))
            `CHK("pwm_a", k != 4, compare_a_flag)
            `CHK("pwm_p", k != 5, compare_p_flag)
        end
        // Single pulse from the trigger pin, ended by the A match
        cfg(mk(STME_MODE_PWM, 2'h3, 1'h1, 1'h0, 1'h1, 1'h0), 10'd20, 3'h1);
        wr(STME_ADDR_CTRL0, 10'h000);
        ext_clock_pin <= 1'h1;
        cyc(4);
        #1 `CHK("lead", 1'h1, timer_out)
        cyc(40);
        #1 `CHK("trail", 1'h0, timer_out)
        `CHK("sp_flag", 1'h1, compare_a_flag)
        rd(STME_ADDR_CTRL0, d); `CHK("auto_off", 10'h000, d)
        rd(STME_ADDR_COUNT, a);
        cyc(10);
        rd(STME_ADDR_COUNT, d); `CHK("stopped", a, d)
        ext_clock_pin <= 1'h0;
        wr(STME_ADDR_CMPA, 10'd300);
        wr(STME_ADDR_CTRL0, 10'h001);
        cyc(5);
        wr(STME_ADDR_CTRL0, 10'h000);
        cyc(3);
        #1 `CHK("sw_end", 1'h0, timer_out)
        // Capture: every edge code, rising then falling edge
        for (int p = 0; p < 4; p++) begin
            cfg(mk(STME_MODE_CAP, p[1:0], 1'h0, 1'h0, 1'h0, 1'h0),
                10'h000, 3'h0);
            cyc(20 + $unsigned($random(seed)) % 50);
            capture_input_pin <= 1'h1;
            cyc(4);
            cap = (p == 0 || p == 2);
            #1 `CHK("cap_rise", cap, compare_a_flag)
            rd(STME_ADDR_CMPA, a); `CHK("cap_val", cap, a != 10'h000)
            wr(STME_ADDR_FLAGS, 10'h003);
            cyc(20);
            capture_input_pin <= 1'h0;
            cyc(4);
            cap = (p == 1 || p == 2);
            #1 `CHK("cap_fall", cap, compare_a_flag)
            rd(STME_ADDR_CMPA, d); `CHK("cap_new", cap, d != a)
            rd(STME_ADDR_COUNT, a);
            rd(STME_ADDR_COUNT, d); `CHK("runs", 1'h1, d != a)
        end
        // Capture with coarse period: count cleared at 128, P flag
        cfg(mk(STME_MODE_CAP, 2'h3, 1'h0, 1'h0, 1'h0, 1'h0), 10'h000, 3'h1);
        cyc(200);
        #1 `CHK("cap_p", 1'h1, compare_p_flag)
        rd(STME_ADDR_COUNT, d); `CHK("cap_clr", 1'h1, d < 10'd128)
        print_verdict;
    end
endmodule : tb
